/* File: hw/cmcr_consts.vh */
// constants for the charger mode and charge current register pair
// assumes an 8-bit register port with a small byte address
`ifndef CMCR_CONSTS_VH
`define CMCR_CONSTS_VH
// register offsets
`define CMCR_OFS_MODE        8'h01
`define CMCR_OFS_FAST_CHARGE_CURRENT        8'h02
// reset values
`define CMCR_RST_MODE        8'h1A
`define CMCR_RST_FAST_CHARGE_CURRENT        8'h91
// mode register fields
`define CMCR_B_SKIP_DIS      7
`define CMCR_B_KICK          6
`define CMCR_B_BOOST_EN      5
`define CMCR_B_CHG_EN        4
`define CMCR_F_FLOOR_HI      3
`define CMCR_F_FLOOR_LO      1
`define CMCR_B_BATSEL        0
// current register fields
`define CMCR_B_RSVD          7
`define CMCR_B_FET_FULL      6
`define CMCR_F_FAST_CHARGE_CURRENT_HI       5
`define CMCR_F_FAST_CHARGE_CURRENT_LO       0
// bits restored by watchdog expiry, per register
`define CMCR_WD_MASK_MODE    8'h70
`define CMCR_WD_MASK_FAST_CHARGE_CURRENT    8'h3F
// input current limit threshold for the blocking FET, code of 700 mA
`define CMCR_ILIM_700_CODE   5'h06
// fast charge step and knee
`define CMCR_FAST_CHARGE_CURRENT_STEP_MA    12'h014
`define CMCR_FAST_CHARGE_CURRENT_KNEE       6'h3B
// fixed currents of the four codes above the knee, in mA
`define CMCR_FAST_CHARGE_CURRENT_MA_TOP0    12'h50A
`define CMCR_FAST_CHARGE_CURRENT_MA_TOP1    12'h550
`define CMCR_FAST_CHARGE_CURRENT_MA_TOP2    12'h596
`define CMCR_FAST_CHARGE_CURRENT_MA_TOP3    12'h5DC
// floor voltage in units of 100 mV
`define CMCR_FLOOR_0         6'h1A
`define CMCR_FLOOR_1         6'h1C
`define CMCR_FLOOR_2         6'h1E
`define CMCR_FLOOR_3         6'h20
`define CMCR_FLOOR_4         6'h22
`define CMCR_FLOOR_5         6'h23
`define CMCR_FLOOR_6         6'h24
`define CMCR_FLOOR_7         6'h25
// boost battery thresholds in units of 100 mV
`define CMCR_BAT_FALL_NORM   6'h1C
`define CMCR_BAT_RISE_NORM   6'h1E
`define CMCR_BAT_FALL_LOW    6'h19
`define CMCR_BAT_RISE_LOW    6'h1C
`endif

/* File: hw/cmcr_fast_charge_current_decode.v */
// fast charge current decoder: six-bit code to milliamps
// assumes a purely combinational use inside the register block
`timescale 1ns/1ps
`default_nettype none
`include "cmcr_consts.vh"
module cmcr_fast_charge_current_decode (
	input  wire [5:0]  code,
	output reg  [11:0] current_ma
);
	// linear up to the knee, then four fixed steps
	always @* begin
		case (code)
			6'h3C:   current_ma = `CMCR_FAST_CHARGE_CURRENT_MA_TOP0;
			6'h3D:   current_ma = `CMCR_FAST_CHARGE_CURRENT_MA_TOP1;
			6'h3E:   current_ma = `CMCR_FAST_CHARGE_CURRENT_MA_TOP2;
			6'h3F:   current_ma = `CMCR_FAST_CHARGE_CURRENT_MA_TOP3;
			// widened first so the product is formed at 12 bits
			default: current_ma = {6'h00, code} * `CMCR_FAST_CHARGE_CURRENT_STEP_MA;
		endcase
	end
endmodule
`default_nettype wire

/* File: hw/cmcr_regs.v */
// mode control and charge current register pair of the charger, with derived controls
// assumes a byte-wide register port already decoded from the serial link
`timescale 1ns/1ps
`default_nettype none
`include "cmcr_consts.vh"
module cmcr_regs (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        reg_reset,
	input  wire        wd_expired,
	input  wire        charge_enable_n,
	input  wire        adapter_present,
	input  wire [4:0]  input_current_limit,
	output reg         watchdog_kick_pulse,
	output reg         light_load_skip_disable,
	output reg         charge_active,
	output reg         boost_active,
	output reg  [5:0]  system_floor_voltage,
	output reg  [5:0]  boost_exit_bat,
	output reg  [5:0]  boost_start_bat,
	output reg         blocking_fet_full_on,
	output reg  [11:0] fast_charge_current
);
	// ************************************************************
	// storage
	// ************************************************************
	localparam [7:0] MODE_DFLT = `CMCR_RST_MODE;
	localparam [7:0] FAST_CHARGE_CURRENT_DFLT = `CMCR_RST_FAST_CHARGE_CURRENT;
	localparam [7:0] KICK_MASK = 8'h01 << `CMCR_B_KICK;
	reg  [7:0]  mode_reg;
	reg  [6:0]  fast_charge_current_reg;      // reserved bit 7 is not stored
	wire [7:0]  next_mode;
	wire [7:0]  fast_charge_current_wide;
	wire [7:0]  fast_charge_current_restored;
	wire [11:0] fast_charge_current_ma;
	wire        mode_wr_ok;
	wire        fast_charge_current_wr_ok;
	wire        chg_ok;

	// mask-restore helper shared by both registers
	function [7:0] restore;
		input [7:0] cur;
		input [7:0] dflt;
		input [7:0] mask;
		begin
			restore = (cur & ~mask) | (dflt & mask);
		end
	endfunction

	// address match shared by both write qualifiers
	function addr_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	// ************************************************************
	// write qualification
	// ************************************************************
	// reset and expiry win over a same-cycle host write, kick included
	assign mode_wr_ok = reg_wr && addr_hit(reg_addr, `CMCR_OFS_MODE)
		&& !reg_reset && !wd_expired;
	assign fast_charge_current_wr_ok = reg_wr && addr_hit(reg_addr, `CMCR_OFS_FAST_CHARGE_CURRENT)
		&& !reg_reset && !wd_expired;

	// ************************************************************
	// register writes
	// ************************************************************
	// reset beats expiry beats host write; kick bit never stays set
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= MODE_DFLT;
			fast_charge_current_reg <= FAST_CHARGE_CURRENT_DFLT[6:0];
		end else if (reg_reset) begin
			mode_reg <= MODE_DFLT;
			fast_charge_current_reg <= FAST_CHARGE_CURRENT_DFLT[6:0];
		end else if (wd_expired) begin
			mode_reg <= restore(mode_reg, MODE_DFLT, `CMCR_WD_MASK_MODE);
			fast_charge_current_reg <= fast_charge_current_restored[6:0];
		end else begin
			mode_reg <= next_mode;
			if (fast_charge_current_wr_ok)
				fast_charge_current_reg <= reg_wdata[`CMCR_B_FET_FULL:`CMCR_F_FAST_CHARGE_CURRENT_LO];
		end
	end

	// expiry restores the current code but keeps the fet choice
	assign fast_charge_current_wide     = {1'b1, fast_charge_current_reg};
	assign fast_charge_current_restored = restore(fast_charge_current_wide, FAST_CHARGE_CURRENT_DFLT, `CMCR_WD_MASK_FAST_CHARGE_CURRENT);

	// kick bit stored as written for one cycle then cleared
	assign next_mode = mode_wr_ok ? reg_wdata : (mode_reg & ~KICK_MASK);

	// ************************************************************
	// read path
	// ************************************************************
	// unmapped addresses read zero; reserved bit 7 reads one
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`CMCR_OFS_MODE: reg_rdata <= mode_reg;
				`CMCR_OFS_FAST_CHARGE_CURRENT: reg_rdata <= {1'b1, fast_charge_current_reg};
				default:        reg_rdata <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// derived controls
	// ************************************************************
	cmcr_fast_charge_current_decode u_dec (
		.code       (fast_charge_current_reg[`CMCR_F_FAST_CHARGE_CURRENT_HI:`CMCR_F_FAST_CHARGE_CURRENT_LO]),
		.current_ma (fast_charge_current_ma)
	);

	// zero current code vetoes charging regardless of pin and bit
	assign chg_ok = !charge_enable_n && mode_reg[`CMCR_B_CHG_EN]
		&& (fast_charge_current_reg[`CMCR_F_FAST_CHARGE_CURRENT_HI:`CMCR_F_FAST_CHARGE_CURRENT_LO] != 6'h00);

	// ************************************************************
	// registered outputs
	// ************************************************************
	// kick pulse only for a write that actually lands in the register
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_kick_pulse <= 1'b0;
		end else begin
			watchdog_kick_pulse <= mode_wr_ok && reg_wdata[`CMCR_B_KICK];
		end
	end

	// skip disable is a plain copy of its bit
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			light_load_skip_disable <= 1'b0;
		end else begin
			light_load_skip_disable <= mode_reg[`CMCR_B_SKIP_DIS];
		end
	end

	// with both enables set the adapter picks the mode; no debounce here
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_active <= 1'b0;
			boost_active  <= 1'b0;
		end else begin
			charge_active <= chg_ok && adapter_present;
			boost_active  <= mode_reg[`CMCR_B_BOOST_EN] && !adapter_present;
		end
	end

	// system floor in 100 mV units, registered so a code change never glitches
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			system_floor_voltage <= `CMCR_FLOOR_5;
		end else begin
			case (mode_reg[`CMCR_F_FLOOR_HI:`CMCR_F_FLOOR_LO])
				3'h0:    system_floor_voltage <= `CMCR_FLOOR_0;
				3'h1:    system_floor_voltage <= `CMCR_FLOOR_1;
				3'h2:    system_floor_voltage <= `CMCR_FLOOR_2;
				3'h3:    system_floor_voltage <= `CMCR_FLOOR_3;
				3'h4:    system_floor_voltage <= `CMCR_FLOOR_4;
				3'h5:    system_floor_voltage <= `CMCR_FLOOR_5;
				3'h6:    system_floor_voltage <= `CMCR_FLOOR_6;
				default: system_floor_voltage <= `CMCR_FLOOR_7;
			endcase
		end
	end

	// boost battery thresholds; the pair always switches together
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boost_exit_bat  <= `CMCR_BAT_FALL_NORM;
			boost_start_bat <= `CMCR_BAT_RISE_NORM;
		end else begin
			if (mode_reg[`CMCR_B_BATSEL]) begin
				boost_exit_bat  <= `CMCR_BAT_FALL_LOW;
				boost_start_bat <= `CMCR_BAT_RISE_LOW;
			end else begin
				boost_exit_bat  <= `CMCR_BAT_FALL_NORM;
				boost_start_bat <= `CMCR_BAT_RISE_NORM;
			end
		end
	end

	// full on forced from 700 mA up or by the fet bit; computed in every mode, boost included
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blocking_fet_full_on <= 1'b1;
		end else begin
			blocking_fet_full_on <= (input_current_limit >= `CMCR_ILIM_700_CODE)
				|| fast_charge_current_reg[`CMCR_B_FET_FULL];
		end
	end

	// current reads zero whenever charging is not allowed, adapter aside
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_charge_current <= 12'h000;
		end else begin
			fast_charge_current <= chg_ok ? fast_charge_current_ma : 12'h000;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/cmcr_host.sv */
// host model driving the byte register port on falling edges
// assumes the bench calls xfer one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module cmcr_host (
	input  wire        core_clk,
	output logic [7:0] reg_addr = 8'h00,
	output logic       reg_wr = 1'b0,
	output logic [7:0] reg_wdata = 8'h00,
	output logic       reg_rd = 1'b0
);
	// one-cycle strobe; lines scrambled once released so stale data never matches
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

/* File: testbench/cmcr_regs_assertions.sv */
// checker of the mode and charge current register pair
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module cmcr_regs_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_reset,
	input wire logic        wd_expired,
	input wire logic        charge_enable_n,
	input wire logic        adapter_present,
	input wire logic        watchdog_kick_pulse,
	input wire logic        light_load_skip_disable,
	input wire logic        charge_active,
	input wire logic        boost_active,
	input wire logic        blocking_fet_full_on,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic [4:0]  input_current_limit,
	input wire logic [11:0] fast_charge_current
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// a mode write that no reset or expiry overrides
	sequence s_mode_wr;
		reg_wr && reg_addr == 8'h01 && !reg_reset && !wd_expired;
	endsequence
	sequence s_mode_settle;
		s_mode_wr ##1 !reg_reset && !reg_wr;
	endsequence
	// a landing mode write that carries the kick bit
	sequence s_kick_wr;
		s_mode_wr ##0 reg_wdata[6];
	endsequence
	a_kick_cause: assert property (s_kick_wr |=> watchdog_kick_pulse)
		else $error("kick write gave no pulse");
	a_kick_once: assert property (watchdog_kick_pulse && !reg_wr |=> !watchdog_kick_pulse)
		else $error("kick pulse too long");
	a_skip_copy: assert property (s_mode_settle |=> light_load_skip_disable == $past(reg_wdata[7], 2))
		else $error("skip disable not following bit 7");
	a_fet_limit: assert property (input_current_limit >= 5'h06 |=> blocking_fet_full_on)
		else $error("fet not full at high limit");
	a_pin_blocks: assert property (charge_enable_n |=> !charge_active)
		else $error("charging with pin high");
	a_zero_current: assert property (charge_active |-> fast_charge_current != 12'h000)
		else $error("charging at zero current");
	a_boost_adapter: assert property (adapter_present |=> !boost_active)
		else $error("boost with adapter present");
	a_rsvd_reads: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata[7])
		else $error("reserved bit read as 0");
endmodule
bind cmcr_regs cmcr_regs_chk chk (
	.core_clk                (core_clk),
	.rst_n                   (rst_n),
	.reg_wr                  (reg_wr),
	.reg_rd                  (reg_rd),
	.reg_reset               (reg_reset),
	.wd_expired              (wd_expired),
	.charge_enable_n         (charge_enable_n),
	.adapter_present         (adapter_present),
	.watchdog_kick_pulse     (watchdog_kick_pulse),
	.light_load_skip_disable (light_load_skip_disable),
	.charge_active           (charge_active),
	.boost_active            (boost_active),
	.blocking_fet_full_on    (blocking_fet_full_on),
	.reg_addr                (reg_addr),
	.reg_wdata               (reg_wdata),
	.reg_rdata               (reg_rdata),
	.input_current_limit     (input_current_limit),
	.fast_charge_current     (fast_charge_current)
);
`default_nettype wire

/* File: testbench/cmcr_regs_bench.sv */
// self-checking bench of the mode and charge current registers
// assumes the host model owns the register port, the bench the rest
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module cmcr_regs_bench;
	logic        core_clk = 1'b0, rst_n = 1'b0, reg_reset = 1'b0, wd_expired = 1'b0, rd_q = 1'b0;
	logic        charge_enable_n = 1'b0, adapter_present = 1'b1, chg_exp = 1'b0;
	logic [4:0]  input_current_limit = 5'h00;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
	wire         reg_wr, reg_rd, watchdog_kick_pulse, light_load_skip_disable;
	wire         charge_active, boost_active, blocking_fet_full_on;
	wire  [5:0]  system_floor_voltage, boost_exit_bat, boost_start_bat;
	wire  [11:0] fast_charge_current;
	logic [7:0]  exp_q[$];
	logic [7:0]  d, seen;
	logic [11:0] ma;
	logic [5:0]  tbl[8] = '{6'h00, 6'h01, 6'h11, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F};
	int          bad_count = 0, compares = 0;
	int          kick_count = 0, k0 = 0;
	cmcr_host host (
		.core_clk  (core_clk),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.reg_rd    (reg_rd)
	);
	cmcr_regs uut (
		.core_clk                (core_clk),
		.rst_n                   (rst_n),
		.reg_addr                (reg_addr),
		.reg_wr                  (reg_wr),
		.reg_wdata               (reg_wdata),
		.reg_rd                  (reg_rd),
		.reg_rdata               (reg_rdata),
		.reg_reset               (reg_reset),
		.wd_expired              (wd_expired),
		.charge_enable_n         (charge_enable_n),
		.adapter_present         (adapter_present),
		.input_current_limit     (input_current_limit),
		.watchdog_kick_pulse     (watchdog_kick_pulse),
		.light_load_skip_disable (light_load_skip_disable),
		.charge_active           (charge_active),
		.boost_active            (boost_active),
		.system_floor_voltage    (system_floor_voltage),
		.boost_exit_bat          (boost_exit_bat),
		.boost_start_bat         (boost_start_bat),
		.blocking_fet_full_on    (blocking_fet_full_on),
		.fast_charge_current     (fast_charge_current)
	);
	initial forever #20 core_clk = ~core_clk;
	// read data lands one edge after the strobe; compare with the oldest note
	always @(posedge core_clk) begin
		kick_count <= kick_count + int'(watchdog_kick_pulse);
		rd_q <= reg_rd;
		if (rd_q) begin
			seen = exp_q.pop_front();
			`CHK("reg_rdata", seen, reg_rdata)
		end
	end
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.xfer(a, 8'h00, 1'b0);
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk) s = 1'b1;
		@(negedge core_clk) s = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h10b0));
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		rd(8'h01, 8'h1A);
		rd(8'h02, 8'h91);
		rd(8'h03, 8'h00);
		// every floor code, other mode bits and adapter random
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			d[3:1] = 3'(i);
			adapter_present = 1'($urandom);
			k0 = kick_count;
			host.xfer(8'h01, d, 1'b1);
			repeat (2) @(negedge core_clk);
			`CHK("floor", 6'(i < 5 ? 26 + 2 * i : 30 + i), system_floor_voltage)
			`CHK("skip", d[7], light_load_skip_disable)
			`CHK("boost", d[5] & !adapter_present, boost_active)
			`CHK("bat", d[0] ? 12'h65C : 12'h71E, {boost_exit_bat, boost_start_bat})
			`CHK("kick", int'(d[6]), kick_count - k0)
			`CHK("charge", d[4] & adapter_present, charge_active)
			`CHK("current", d[4] ? 12'h154 : 12'h000, fast_charge_current)
			rd(8'h01, d & 8'hBF);
		end
		adapter_present = 1'b1;
		host.xfer(8'h01, 8'h10, 1'b1);
		// current codes zero, one, 0x11, the knee and above, then random ones, pin high last
		for (int i = 0; i < 10; i++) begin
			d = 8'($urandom);
			if (i < 8) d[5:0] = tbl[i];
			input_current_limit = 5'($urandom);
			charge_enable_n = (i == 9);
			host.xfer(8'h02, d, 1'b1);
			repeat (2) @(negedge core_clk);
			ma = d[5:0] > 6'h3B ? 12'h50A + 12'h046 * (d[5:0] - 6'h3C) : 12'h014 * d[5:0];
			chg_exp = !charge_enable_n && d[5:0] != 6'h00;
			`CHK("charge", chg_exp, charge_active)
			`CHK("current", chg_exp ? ma : 12'h000, fast_charge_current)
			`CHK("fet", input_current_limit >= 5'h06 || d[6], blocking_fet_full_on)
			rd(8'h02, {1'b1, d[6:0]});
		end
		// expiry restores only its fields, register reset restores all
		host.xfer(8'h01, 8'hE7, 1'b1);
		host.xfer(8'h02, 8'h7F, 1'b1);
		pulse(wd_expired);
		rd(8'h01, 8'h97);
		rd(8'h02, 8'hD1);
		pulse(reg_reset);
		rd(8'h01, 8'h1A);
		rd(8'h02, 8'h91);
		// mid-run reset: outputs return to their reset values while it is held
		@(negedge core_clk) rst_n = 1'b0;
		@(negedge core_clk);
		`CHK("rst floor", 6'h23, system_floor_voltage)
		`CHK("rst bat", 12'h71E, {boost_exit_bat, boost_start_bat})
		`CHK("rst fet", 1'b1, blocking_fet_full_on)
		`CHK("rst rdata", 8'h00, reg_rdata)
		rst_n = 1'b1;
		rd(8'h01, 8'h1A);
		repeat (3) @(negedge core_clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
